// >>> logic/flbr_pkg.sv
// Purpose: constants and types of the flash page erase / read-ahead core
// Assumes: one 100 MHz clock, AHB-Lite register port, fabric-side pins
// Notes:  address = {sector, page, block, word}, two bits each
package flbr_pkg;
    // clock and timing
    localparam int         CLK_MHZ      = 100;
    localparam int         FETCH_NS     = 40;
    localparam int         FETCH_CYC    = (FETCH_NS * CLK_MHZ + 999) / 1000;
    localparam int         MISS_MAX_BSY = 9;
    // array geometry
    localparam int         ADDR_W       = 8;
    localparam int         IDX_W        = 10;
    localparam int         MEM_WORDS    = 1024;
    localparam int         PAGES        = 16;
    localparam logic [7:0] WRITE_THRESH = 8'hc8;
    // region codes of a read
    localparam logic [1:0] RG_DATA      = 2'h0;
    localparam logic [1:0] RG_SPARE     = 2'h1;
    localparam logic [1:0] RG_AUX       = 2'h2;
    // erase status codes
    localparam logic [1:0] ST_OK        = 2'h0;
    localparam logic [1:0] ST_UNERASED  = 2'h1;
    localparam logic [1:0] ST_ECC       = 2'h2;
    localparam logic [1:0] ST_WCOUNT    = 2'h3;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATE    = 8'h04;
    localparam logic [7:0] OFS_IRQ_STS  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MSK  = 8'h0c;
    localparam logic [7:0] OFS_ECC_FLT  = 8'h10;
    localparam logic [7:0] OFS_PROTECT  = 8'h14;
    // reset values and irq bit positions
    localparam logic [0:0] CTRL_RST     = 1'h1;
    localparam logic [2:0] IRQ_MSK_RST  = 3'h0;
    localparam int         IRQ_DONE     = 0;
    localparam int         IRQ_ERR      = 1;
    localparam int         IRQ_MISS     = 2;

    typedef enum logic [1:0] {
        FLBR_IDLE    = 2'b00,
        FLBR_LA_WAIT = 2'b01,
        FLBR_FETCH   = 2'b11,
        FLBR_ERASE   = 2'b10
    } flbr_state_t;

    // request group from fabric logic
    typedef struct packed {
        logic              rd;
        logic [1:0]        region;
        logic [ADDR_W-1:0] addr;
    } flbr_req_t;

    // guard group accompanying an erase
    typedef struct packed {
        logic page_write_guard_req;
        logic buffer_loss_guard;
    } flbr_guard_t;
endpackage : flbr_pkg

// >>> logic/flbr_core.sv
// Purpose: page erase sequencer and read-ahead buffer of the embedded flash
// Assumes: fabric inputs synchronous to clk_in; AHB-Lite single word access
// Notes:  zero-wait-state slave; hrdata is prepared in the address phase
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module flbr_core
    import flbr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // fabric side
    input  wire flbr_req_t   req_in,
    input  wire logic        page_clear_request_in,
    input  wire flbr_guard_t guard_in,
    output logic             busy_out,
    output logic [1:0]       status_out,
    output logic             erase_done_out,
    output logic             rd_valid_out,
    output logic [31:0]      rd_data_out,
    output logic             irq_out,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out
);
    logic [31:0]      mem_r [MEM_WORDS];
    logic [7:0]       wcount_r [PAGES];
    flbr_state_t      state_r;
    logic [7:0]       tag_buf_r;
    logic             buf_vld_r;
    logic [7:0]       tag_la_r;
    logic             la_pend_r;
    logic             la_vld_r;
    logic [2:0]       la_cnt_r;
    logic [2:0]       fetch_cnt_r;
    logic [7:0]       tag_want_r;
    logic [3:0]       er_word_r;
    logic [3:0]       er_page_r;
    logic             clr_req_q_r;
    logic [15:0]      protect_r;
    logic             loss_mode_r;
    logic [3:0]       loss_page_r;
    logic [15:0]      ecc_flt_r;
    logic [0:0]       ctrl_r;
    logic [2:0]       irq_sts_r;
    logic [2:0]       irq_msk_r;
    logic [2:0]       irq_set;
    logic             wr_pend_r;
    logic [7:0]       wr_ofs_r;
    logic             ahb_go;
    logic             sts_rd;
    logic [7:0]       tag_req;
    logic [3:0]       req_page;
    logic             clr_edge;
    logic             la_hit;

    // next block after a given tag {region, sector, page, block}; spare goes to block 0 of the next sector, aux to the next page
    function automatic logic [7:0] next_tag(input logic [7:0] t);
        logic [7:0] n;
        n = t;
        unique case (t[7:6])
            RG_SPARE : n = {t[7:6], t[5:4] + 2'h1, 4'h0};
            RG_AUX   : n = {t[7:6], t[5:2] + 4'h1, t[1:0]};
            default  : n = {t[7:6], t[5:0] + 6'h01};
        endcase
        return n;
    endfunction : next_tag

    assign tag_req  = {req_in.region, req_in.addr[7:2]};
    assign req_page = req_in.addr[7:4];
    assign clr_edge = page_clear_request_in & ~clr_req_q_r;
    assign la_hit   = la_vld_r & (tag_req == tag_la_r);
    assign ahb_go   = hsel_in & htrans_in[1] & hready_in;
    assign sts_rd   = ahb_go & ~hwrite_in & (haddr_in[7:0] == OFS_IRQ_STS);

    // request edge: a held level starts only one erase
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            clr_req_q_r <= 1'b0;
        else
            clr_req_q_r <= page_clear_request_in;
    end

    // main sequencer: erase, miss handling, buffer tags
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r     <= FLBR_IDLE;
            tag_buf_r   <= 8'h00;
            buf_vld_r   <= 1'b0;
            tag_want_r  <= 8'h00;
            fetch_cnt_r <= 3'h0;
            er_word_r   <= 4'h0;
            er_page_r   <= 4'h0;
            busy_out    <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                FLBR_IDLE :
                begin
                    if (clr_edge)
                    begin
                        er_page_r <= req_page;
                        er_word_r <= 4'h0;
                        buf_vld_r <= 1'b0;          // array changes under it
                        busy_out  <= 1'b1;
                        state_r   <= FLBR_ERASE;
                    end
                    else if (req_in.rd && !(buf_vld_r &&
                             tag_req == tag_buf_r) && !la_hit)
                    begin
                        tag_want_r  <= tag_req;
                        fetch_cnt_r <= 3'(FETCH_CYC);
                        busy_out    <= 1'b1;
                        state_r     <= la_pend_r ? FLBR_LA_WAIT
                                                 : FLBR_FETCH;
                    end
                    else if (req_in.rd && la_hit)
                    begin
                        tag_buf_r <= tag_la_r;
                        buf_vld_r <= 1'b1;
                    end
                end
                FLBR_LA_WAIT :
                begin
                    // the started look-ahead cannot be aborted
                    if (!la_pend_r)
                        state_r <= FLBR_FETCH;
                end
                FLBR_FETCH :
                begin
                    if (fetch_cnt_r == 3'h1)
                    begin
                        tag_buf_r <= tag_want_r;
                        buf_vld_r <= 1'b1;
                        busy_out  <= 1'b0;
                        state_r   <= FLBR_IDLE;
                    end
                    fetch_cnt_r <= fetch_cnt_r - 3'h1;
                end
                FLBR_ERASE :
                begin
                    er_word_r <= er_word_r + 4'h1;
                    if (er_word_r == 4'hf)
                    begin
                        busy_out <= 1'b0;
                        state_r  <= FLBR_IDLE;
                    end
                end
            endcase
        end
    end

    // background look-ahead fetch of the block after the buffer
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tag_la_r  <= 8'h00;
            la_pend_r <= 1'b0;
            la_vld_r  <= 1'b0;
            la_cnt_r  <= 3'h0;
        end
        else if (la_pend_r)
        begin
            la_cnt_r <= la_cnt_r - 3'h1;
            if (la_cnt_r == 3'h1)
            begin
                la_pend_r <= 1'b0;
                la_vld_r  <= 1'b1;
            end
        end
        else if (state_r == FLBR_ERASE || !buf_vld_r || !ctrl_r[0])
            la_vld_r <= 1'b0;
        else if (!la_vld_r || tag_la_r != next_tag(tag_buf_r))
        begin
            tag_la_r  <= next_tag(tag_buf_r);
            la_pend_r <= 1'b1;
            la_vld_r  <= 1'b0;
            la_cnt_r  <= 3'(FETCH_CYC);
        end
    end

    // read data: delivered one cycle after a hit in the buffer
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= 32'h0000_0000;
        end
        else
        begin
            rd_valid_out <= 1'b0;
            if ((state_r == FLBR_IDLE && req_in.rd && !clr_edge &&
                 ((buf_vld_r && tag_req == tag_buf_r) || la_hit)) ||
                (state_r == FLBR_FETCH && fetch_cnt_r == 3'h1))
            begin
                rd_valid_out <= 1'b1;               // addr held
                rd_data_out  <= mem_r[{req_in.region, req_in.addr}];
            end
        end
    end

    // erase outcome, guards and write counts
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            status_out     <= ST_OK;
            erase_done_out <= 1'b0;
            protect_r      <= 16'h0000;
            loss_mode_r    <= 1'b0;
            loss_page_r    <= 4'h0;
            for (int i = 0; i < PAGES; i++)
                wcount_r[i] <= 8'h00;
        end
        else
        begin
            erase_done_out <= 1'b0;
            if (state_r == FLBR_ERASE && er_word_r == 4'hf)
            begin
                erase_done_out <= 1'b1;
                if (protect_r[er_page_r])
                    status_out <= ST_UNERASED;
                else if (loss_mode_r && loss_page_r != er_page_r)
                    status_out <= ST_UNERASED;
                else
                begin
                    wcount_r[er_page_r] <= wcount_r[er_page_r] + 8'h01;
                    if (ecc_flt_r[er_page_r])
                        status_out <= ST_ECC;
                    else if (wcount_r[er_page_r] > WRITE_THRESH)
                        status_out <= ST_WCOUNT;
                    else
                        status_out <= ST_OK;
                    // guards applied as for a page program
                    protect_r[er_page_r] <= guard_in.page_write_guard_req;
                    loss_mode_r <= guard_in.buffer_loss_guard;
                    loss_page_r <= er_page_r;
                end
            end
        end
    end

    // array contents: erase clears one word per cycle; the page's spare
    // and aux words go with it, else those regions never read as known
    always_ff @(posedge clk_in)
    begin
        if (state_r == FLBR_ERASE && !protect_r[er_page_r] &&
            !(loss_mode_r && loss_page_r != er_page_r))
        begin
            mem_r[{RG_DATA, er_page_r, er_word_r}]  <= 32'h0000_0000;
            mem_r[{RG_SPARE, er_page_r, er_word_r}] <= 32'h0000_0000;
            mem_r[{RG_AUX, er_page_r, er_word_r}]   <= 32'h0000_0000;
        end
    end

    // interrupt events
    assign irq_set[IRQ_DONE] = erase_done_out & (status_out == ST_OK);
    assign irq_set[IRQ_ERR]  = erase_done_out & (status_out != ST_OK);
    assign irq_set[IRQ_MISS] = state_r == FLBR_FETCH && fetch_cnt_r == 3'h1;

    // sticky status, cleared by reading it; a new event wins
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            irq_sts_r <= 3'h0;
            irq_out   <= 1'b0;
        end
        else
        begin
            irq_sts_r <= (sts_rd ? 3'h0 : irq_sts_r) | irq_set;
            irq_out   <= |(((sts_rd ? 3'h0 : irq_sts_r) | irq_set) & irq_msk_r);
        end
    end

    // bus write: latched in address phase, applied in data phase
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 8'h00;
            ctrl_r    <= CTRL_RST;
            irq_msk_r <= IRQ_MSK_RST;
            ecc_flt_r <= 16'h0000;
        end
        else
        begin
            if (hready_in)
            begin
                wr_pend_r <= ahb_go & hwrite_in;
                wr_ofs_r  <= haddr_in[7:0];
            end
            if (wr_pend_r)
            begin
                unique case (wr_ofs_r)
                    OFS_CTRL    : ctrl_r    <= hwdata_in[0:0];
                    OFS_IRQ_MSK : irq_msk_r <= hwdata_in[2:0];
                    OFS_ECC_FLT : ecc_flt_r <= hwdata_in[15:0];
                    default     : ;             // read-only or unmapped
                endcase
            end
        end
    end

    // bus read: data formed in address phase, zero-wait OKAY always
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else if (ahb_go && !hwrite_in)
        begin
            unique case (haddr_in[7:0])
                OFS_CTRL    : hrdata_out <= {31'h0, ctrl_r};
                OFS_STATE   : hrdata_out <= {26'h0, loss_mode_r, la_vld_r,
                                             status_out, state_r != FLBR_IDLE,
                                             busy_out};
                OFS_IRQ_STS : hrdata_out <= {29'h0, irq_sts_r};
                OFS_IRQ_MSK : hrdata_out <= {29'h0, irq_msk_r};
                OFS_ECC_FLT : hrdata_out <= {16'h0, ecc_flt_r};
                OFS_PROTECT : hrdata_out <= {16'h0, protect_r};
                default     : hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // hsize is fixed at word; a narrower size is served as a word
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize_in, haddr_in[31:8], htrans_in[0]};
endmodule : flbr_core

// >>> dv/flbr_properties.sv
// Purpose: timing properties of the flash erase / read-ahead core
// Assumes: one clock domain; fabric holds requests while busy
// Notes:  bound to flbr_core from the testbench top file
`timescale 1ns/1ps
module flbr_checker
    import flbr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire flbr_req_t  req_in,
    input  wire logic       page_clear_request_in,
    input  wire logic       busy_out,
    input  wire logic [1:0] status_out,
    input  wire logic       erase_done_out,
    input  wire logic       rd_valid_out,
    input  wire logic       hreadyout_out,
    input  wire logic       hresp_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    // erase: busy for exactly sixteen cycles, then one done pulse
    erase_span_a: assert property ($rose(busy_out) && $past(page_clear_request_in)
        |-> ##16 (erase_done_out && !busy_out))
        else $error("erase did not end after sixteen busy cycles");
    done_len_a: assert property (erase_done_out
        |-> $past(busy_out, 16) && !$past(busy_out, 17))
        else $error("erase done without a sixteen cycle busy span");
    done_pulse_a: assert property (erase_done_out |=> !erase_done_out)
        else $error("erase done longer than one cycle");
    // status only moves when an erase ends
    status_hold_a: assert property (!erase_done_out |-> $stable(status_out))
        else $error("status changed outside erase end");
    // a missed read pays at most nine busy cycles, data on busy fall
    miss_bound_a: assert property ($rose(busy_out) && !$past(page_clear_request_in)
        |-> ##[1:9] !busy_out)
        else $error("read miss busy longer than nine cycles");
    miss_data_a: assert property ($fell(busy_out) && !erase_done_out
        |-> rd_valid_out)
        else $error("no read data when miss busy ended");
    valid_cause_a: assert property (rd_valid_out |-> $past(req_in.rd))
        else $error("read data without a read request");
    valid_idle_a: assert property (rd_valid_out |-> !busy_out)
        else $error("read data while busy");
    // zero-wait slave with fixed OKAY response
    hready_one_a: assert property (hreadyout_out)
        else $error("bus slave inserted wait state");
    okay_resp_a: assert property (!hresp_out)
        else $error("bus slave gave non-okay response");
endmodule : flbr_checker

// >>> dv/flbr_fabric_model.sv
// Purpose: fabric user logic driving the flash control pins
// Assumes: changes only right after a rising edge
// Notes:  requests are held until the core answers
`timescale 1ns/1ps
module flbr_fabric_model
    import flbr_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        busy_in,
    input  wire logic        done_in,
    input  wire logic        valid_in,
    input  wire logic [31:0] data_in,
    output flbr_req_t        req_out,
    output logic             clear_out,
    output flbr_guard_t      guard_out
);
    // quiet pins from time zero
    initial
    begin
        req_out = '0;
        clear_out = 1'b0;
        guard_out = '0;
    end

    // clear request and guards held until done: no change while busy
    task automatic erase(input logic [3:0] p, input flbr_guard_t g,
                         output logic ok);
        int n;
        n = 0;
        @(posedge clk_in);
        req_out.addr <= {p, 4'h0};
        guard_out    <= g;
        clear_out    <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end while (done_in !== 1'b1 && n < 40);
        ok = done_in;
        clear_out <= 1'b0;
        guard_out <= '0;
    endtask : erase

    // read held until data; n counts edges, b the busy ones seen
    task automatic read(input logic [1:0] r, input logic [7:0] a,
                        output int n, output int b, output logic [31:0] d);
        n = 0;
        b = 0;
        @(posedge clk_in);
        req_out <= '{rd: 1'b1, region: r, addr: a};
        do
        begin
            @(posedge clk_in);
            n++;
            b += int'(busy_in);
        end while (valid_in !== 1'b1 && n < 30);
        d = data_in;
        req_out.rd <= 1'b0;
    endtask : read
endmodule : flbr_fabric_model

// >>> dv/testbench.sv
// Purpose: self-checking bench of the flash erase / read-ahead core
// Assumes: bench is the AHB-Lite master; model plays the fabric
// Notes:  array is known only after erase, so every read expects 0
`timescale 1ns/1ps
module testbench;
    import flbr_pkg::*;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    flbr_req_t   req;
    flbr_guard_t guard;
    logic        clr, busy, done, rdv, irq, hrdy, hresp;
    logic [1:0]  status;
    logic [31:0] rdata, hrdata;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    // pairs: a first read, then the block the look-ahead should hold
    logic [1:0]  rg [6] = '{RG_DATA, RG_DATA, RG_DATA, RG_SPARE, RG_SPARE, RG_AUX};
    logic [7:0]  fa [6] = '{8'h00, 8'h0c, 8'hfc, 8'h00, 8'hc0, 8'h00};
    logic [7:0]  ta [6] = '{8'h04, 8'h10, 8'h00, 8'h40, 8'h00, 8'h10};

    // 100 MHz clock
    always #5 clk_in = ~clk_in;

    flbr_core flbr_core_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .req_in(req), .page_clear_request_in(clr), .guard_in(guard),
        .busy_out(busy), .status_out(status), .erase_done_out(done),
        .rd_valid_out(rdv), .rd_data_out(rdata), .irq_out(irq),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
        .hresp_out(hresp));

    flbr_fabric_model flbr_fabric_model_inst (.clk_in(clk_in),
        .busy_in(busy), .done_in(done), .valid_in(rdv), .data_in(rdata),
        .req_out(req), .clear_out(clr), .guard_out(guard));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one single-word transfer; the master never assumes a latency
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic er(input logic [3:0] p, input flbr_guard_t g,
                      input logic [1:0] e);
        logic ok;
        flbr_fabric_model_inst.erase(p, g, ok);
        chk("erase_done", 32'h1, {31'h0, ok});
        chk("status", {30'h0, e}, {30'h0, status});
    endtask : er

    // hit: data on the edge after the take, no busy at all
    task automatic rd(input logic [1:0] r, input logic [7:0] a,
                      input logic hit);
        int n, b;
        logic [31:0] d;
        flbr_fabric_model_inst.read(r, a, n, b, d);
        chk("read_data", 32'h0, d);
        if (hit)
            chk("hit_wait", 32'h2, 32'(n));
        else
            chk("miss_busy", 32'h1, {31'h0, b > 0 && b <= MISS_MAX_BSY});
    endtask : rd

    // hang guard, far above the few thousand cycles needed
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // main sequence
    initial
    begin
        logic [31:0] v;
        logic        ok;
        int          n, b;
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        ahb(1'b0, OFS_CTRL, 32'h0, v);
        chk("ctrl_reset", 32'h1, v);
        ahb(1'b0, 8'h40, 32'h0, v);
        chk("unmapped", 32'h0, v);
        for (int p = 0; p < PAGES; p++)
            er(4'(p), '0, ST_OK);
        ahb(1'b1, OFS_IRQ_MSK, 32'h1, v);
        ahb(1'b0, OFS_IRQ_STS, 32'h0, v);
        er(4'h0, '0, ST_OK);
        repeat (2) @(posedge clk_in);
        chk("irq_set", 32'h1, {31'h0, irq});
        ahb(1'b0, OFS_IRQ_STS, 32'h0, v);
        chk("irq_sts", 32'h1, v);
        repeat (2) @(posedge clk_in);
        chk("irq_clr", 32'h0, {31'h0, irq});
        ahb(1'b1, OFS_IRQ_MSK, 32'h0, v);
        // jump away while the look-ahead is still in flight
        rd(RG_DATA, 8'h00, 1'b0);
        rd(RG_DATA, 8'h80, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            flbr_fabric_model_inst.read(rg[i], fa[i], n, b, v);
            repeat (2 * FETCH_CYC + 4) @(posedge clk_in);
            rd(rg[i], ta[i], 1'b1);
        end
        repeat (12) @(posedge clk_in);
        // look-ahead off: the next block is a miss again
        ahb(1'b1, OFS_CTRL, 32'h0, v);
        flbr_fabric_model_inst.read(RG_DATA, 8'h20, n, b, v);
        repeat (2 * FETCH_CYC + 4) @(posedge clk_in);
        rd(RG_DATA, 8'h24, 1'b0);
        // guards, ecc fault and wear limit
        er(4'h2, 2'b10, ST_OK);
        er(4'h2, 2'b00, ST_UNERASED);
        er(4'h4, 2'b01, ST_OK);
        er(4'h6, 2'b01, ST_UNERASED);
        er(4'h4, 2'b00, ST_OK);
        er(4'h6, 2'b00, ST_OK);
        ahb(1'b1, OFS_ECC_FLT, 32'h80, v);
        er(4'h7, 2'b00, ST_ECC);
        ahb(1'b1, OFS_ECC_FLT, 32'h0, v);
        repeat (201) flbr_fabric_model_inst.erase(4'h9, '0, ok);
        er(4'h9, 2'b00, ST_WCOUNT);
        // only page 2 kept its guard; misses, clean and refused erases seen
        ahb(1'b0, OFS_PROTECT, 32'h0, v);
        chk("protect", 32'h4, v);
        ahb(1'b0, OFS_IRQ_STS, 32'h0, v);
        chk("irq_all", 32'h7, v);
        wrap_up();
    end
endmodule : testbench

bind flbr_core flbr_checker flbr_checker_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .req_in(req_in),
    .page_clear_request_in(page_clear_request_in), .busy_out(busy_out),
    .status_out(status_out), .erase_done_out(erase_done_out),
    .rd_valid_out(rd_valid_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out));
